// ### design/rtc_time_set_and_round.sv
`timescale 1ns/100ps
`default_nettype none
//
// Behaviour
// - Weekday word holds only what software writes; never advanced; any 16-bit value kept, even above 6.
// - Minute and second are two-digit BCD bytes sharing one 16-bit word.
// - Command write with top bit set loads running clock from staged words.
// - After a time load the whole command word clears to zero.
// - Command write with bottom bit set and top bit clear rounds running time to zero seconds.
// - Seconds 0-29 drop to zero; 30-59 zero and advance minute with carry.
// - After rounding the command word clears to zero.
// - Tool-path writes to time words apply directly, no command needed.
// - Clock keeps full calendar, counts correctly with leap years through 2099.
module rtc_time_set_and_round
  import rtc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire mem_req_s req,
  output logic [15:0] rdata,
  output logic rvalid,
  output logic [15:0] minute_second_word,
  output logic [15:0] day_hour_word,
  output logic [15:0] year_month_word,
  output logic [15:0] weekday_value,
  output logic cmd_busy
);

  // ----------------------------------------------------------------
  // BCD helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      return {4'(v[7:4] + 4'h1), 4'h0};
    end
    return {v[7:4], 4'(v[3:0] + 4'h1)};
  endfunction : bcd_inc

  function automatic logic [7:0] days_in_month(input logic [7:0] m, input logic [7:0] y);
    logic leap;
    leap = 1'b0;
    // BCD year is a multiple of four when tens parity and units agree
    leap = (y[4] == 1'b0) ? (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8)
                          : (y[3:0] == 4'h2 || y[3:0] == 4'h6);
    case (m)
      8'h02: days_in_month = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: days_in_month = 8'h30;
      default: days_in_month = 8'h31;
    endcase
  endfunction : days_in_month

  // Advance from the minute field upward, seconds left for the caller to set
  function automatic time_s carry_minute(input time_s t);
    time_s r;
    r = t;
    if (t.minute != BCD_MIN_MAX) begin
      r.minute = bcd_inc(t.minute);
      return r;
    end
    r.minute = BCD_RESET;
    if (t.hour != BCD_HOUR_MAX) begin
      r.hour = bcd_inc(t.hour);
      return r;
    end
    r.hour = BCD_RESET;
    if (t.day != days_in_month(t.month, t.year)) begin
      r.day = bcd_inc(t.day);
      return r;
    end
    r.day = DAY_RESET;
    if (t.month != BCD_MONTH_MAX) begin
      r.month = bcd_inc(t.month);
      return r;
    end
    r.month = MONTH_RESET;
    r.year = (t.year == BCD_YEAR_MAX) ? BCD_RESET : bcd_inc(t.year);
    return r;
  endfunction : carry_minute

  // ----------------------------------------------------------------
  // Staged holding words
  // ----------------------------------------------------------------
  logic stage_wr;
  logic [63:0] stage_all;
  logic is_cmd_idx;

  assign is_cmd_idx = (req.idx == IDX_COMMAND);
  assign stage_wr = req.wr && !is_cmd_idx && (req.idx <= IDX_WEEKDAY);

  rtc_stage_mem u_stage (
    .clk(clk),
    .rst_b(rst_b),
    .wr_en(stage_wr),
    .wr_idx(req.idx[1:0]),
    .wr_data(req.wdata),
    .rd_idx(req.idx[1:0]),
    .rd_data(),
    .all_words(stage_all)
  );

  time_s staged;
  assign staged = '{year: stage_all[47:40], month: stage_all[39:32], day: stage_all[31:24],
                    hour: stage_all[23:16], minute: stage_all[15:8], second: stage_all[7:0]};

  // ----------------------------------------------------------------
  // Running clock and command word
  // ----------------------------------------------------------------
  time_s now_q, now_d;
  logic [15:0] weekday_q, weekday_d;
  logic [15:0] cmd_q, cmd_d;
  cmd_state_e st_q, st_d;
  logic [26:0] tick_q, tick_d;
  logic tool_pend_q, tool_pend_d;
  logic [2:0] rd_idx_q, rd_idx_d;
  logic rd_pend_q, rd_pend_d;
  logic [15:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic tick;

  assign tick = (tick_q == TICK_LAST);

  always_comb begin
    now_d = now_q;
    weekday_d = weekday_q;
    cmd_d = cmd_q;
    st_d = st_q;
    tick_d = tick ? 27'h0 : 27'(tick_q + 27'h1);
    tool_pend_d = 1'b0;
    rd_pend_d = req.rd;
    rd_idx_d = req.idx;
    rdata_d = rdata_q;
    rvalid_d = rd_pend_q;

    if (tick) begin
      if (now_q.second == BCD_SEC_MAX) begin
        now_d = carry_minute(now_q);
        now_d.second = BCD_RESET;
      end else begin
        now_d.second = bcd_inc(now_q.second);
      end
    end

    // Weekday is software-owned; out-of-range writes are kept as-is
    if (req.wr && req.idx == IDX_WEEKDAY) begin
      weekday_d = req.wdata;
    end

    // Tool writes commit one cycle later, once the staged word has landed
    if (stage_wr && req.tool) begin
      tool_pend_d = 1'b1;
    end
    if (tool_pend_q) begin
      now_d = staged;
      tick_d = 27'h0;
    end

    case (st_q)
      ST_RUN: begin
        if (req.wr && is_cmd_idx) begin
          cmd_d = req.wdata;
          if (req.wdata[CMD_LOAD_BIT]) begin
            st_d = ST_LOAD;
          end else if (req.wdata[CMD_ROUND_BIT]) begin
            st_d = ST_ROUND;
          end
        end
      end
      ST_LOAD: begin
        now_d = staged;
        tick_d = 27'h0;
        cmd_d = CMD_RESET;
        st_d = ST_RUN;
      end
      ST_ROUND: begin
        if (now_q.second >= ROUND_UP_FROM) begin
          now_d = carry_minute(now_q);
        end
        now_d.second = BCD_RESET;
        tick_d = 27'h0;
        cmd_d = CMD_RESET;
        st_d = ST_RUN;
      end
      default: begin
        st_d = ST_RUN;
        cmd_d = CMD_RESET;
      end
    endcase

    if (rd_pend_q) begin
      case (rd_idx_q)
        IDX_MIN_SEC: rdata_d = {now_q.minute, now_q.second};
        IDX_DAY_HOUR: rdata_d = {now_q.day, now_q.hour};
        IDX_YEAR_MONTH: rdata_d = {now_q.year, now_q.month};
        IDX_WEEKDAY: rdata_d = weekday_q;
        IDX_COMMAND: rdata_d = cmd_q;
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      now_q <= '{year: BCD_RESET, month: MONTH_RESET, day: DAY_RESET,
                 hour: BCD_RESET, minute: BCD_RESET, second: BCD_RESET};
      weekday_q <= WEEKDAY_RESET;
      cmd_q <= CMD_RESET;
      st_q <= ST_RUN;
      tick_q <= 27'h0;
      tool_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      rd_idx_q <= 3'h0;
      rdata_q <= 16'h0000;
      rvalid_q <= 1'b0;
    end else begin
      now_q <= now_d;
      weekday_q <= weekday_d;
      cmd_q <= cmd_d;
      st_q <= st_d;
      tick_q <= tick_d;
      tool_pend_q <= tool_pend_d;
      rd_pend_q <= rd_pend_d;
      rd_idx_q <= rd_idx_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic [15:0] ms_q, dh_q, ym_q, wd_q;
  logic busy_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ms_q <= 16'h0000;
      dh_q <= 16'h0000;
      ym_q <= 16'h0000;
      wd_q <= 16'h0000;
      busy_q <= 1'b0;
    end else begin
      ms_q <= {now_d.minute, now_d.second};
      dh_q <= {now_d.day, now_d.hour};
      ym_q <= {now_d.year, now_d.month};
      wd_q <= weekday_d;
      busy_q <= (st_d != ST_RUN);
    end
  end

  assign minute_second_word = ms_q;
  assign day_hour_word = dh_q;
  assign year_month_word = ym_q;
  assign weekday_value = wd_q;
  assign cmd_busy = busy_q;
  assign rdata = rdata_q;
  assign rvalid = rvalid_q;

endmodule : rtc_time_set_and_round
`default_nettype wire

// ### design/rtc_pkg.sv
package rtc_pkg;

  // ----------------------------------------------------------------
  // Word indices, as seen through the controller memory port
  // ----------------------------------------------------------------
  localparam logic [2:0] IDX_MIN_SEC = 3'h0;
  localparam logic [2:0] IDX_DAY_HOUR = 3'h1;
  localparam logic [2:0] IDX_YEAR_MONTH = 3'h2;
  localparam logic [2:0] IDX_WEEKDAY = 3'h3;
  localparam logic [2:0] IDX_COMMAND = 3'h4;

  // ----------------------------------------------------------------
  // Command word fields and reset values
  // ----------------------------------------------------------------
  localparam int CMD_LOAD_BIT = 15;
  localparam int CMD_ROUND_BIT = 0;
  localparam logic [15:0] CMD_RESET = 16'h0000;
  localparam logic [7:0] BCD_RESET = 8'h00;
  localparam logic [7:0] DAY_RESET = 8'h01;
  localparam logic [7:0] MONTH_RESET = 8'h01;
  localparam logic [15:0] WEEKDAY_RESET = 16'h0000;
  localparam logic [15:0] WEEKDAY_MAX = 16'h0006;

  // ----------------------------------------------------------------
  // Limits and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] BCD_SEC_MAX = 8'h59;
  localparam logic [7:0] BCD_MIN_MAX = 8'h59;
  localparam logic [7:0] BCD_HOUR_MAX = 8'h23;
  localparam logic [7:0] BCD_MONTH_MAX = 8'h12;
  localparam logic [7:0] BCD_YEAR_MAX = 8'h99;
  localparam logic [7:0] ROUND_UP_FROM = 8'h30;
  localparam int CLK_HZ = 125_000_000;
  localparam int TICK_PERIOD_S = 1;
  localparam int TICK_CYCLES = CLK_HZ * TICK_PERIOD_S;
  localparam logic [26:0] TICK_LAST = 27'(TICK_CYCLES - 1);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] day;
    logic [7:0] hour;
    logic [7:0] minute;
    logic [7:0] second;
  } time_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic tool;
    logic [2:0] idx;
    logic [15:0] wdata;
  } mem_req_s;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_LOAD = 2'b01,
    ST_ROUND = 2'b10
  } cmd_state_e;

endpackage : rtc_pkg

// ### design/rtc_stage_mem.sv
`timescale 1ns/100ps
`default_nettype none
// Holding words for the staged time; read data comes out of a register
module rtc_stage_mem
  import rtc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wr_en,
  input wire logic [1:0] wr_idx,
  input wire logic [15:0] wr_data,
  input wire logic [1:0] rd_idx,
  output logic [15:0] rd_data,
  output logic [63:0] all_words
);

  logic [15:0] mem_q [4];
  logic [15:0] mem_d [4];
  logic [15:0] rd_d;
  logic [15:0] rd_q;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      mem_d[i] = mem_q[i];
    end
    if (wr_en) begin
      mem_d[wr_idx] = wr_data;
    end
    rd_d = mem_q[rd_idx];
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_q[0] <= {BCD_RESET, BCD_RESET};
      mem_q[1] <= {DAY_RESET, BCD_RESET};
      mem_q[2] <= {BCD_RESET, MONTH_RESET};
      mem_q[3] <= WEEKDAY_RESET;
      rd_q <= 16'h0000;
    end else begin
      for (int i = 0; i < 4; i++) begin
        mem_q[i] <= mem_d[i];
      end
      rd_q <= rd_d;
    end
  end

  assign rd_data = rd_q;
  assign all_words = {mem_q[3], mem_q[2], mem_q[1], mem_q[0]};

endmodule : rtc_stage_mem
`default_nettype wire

// ### bench/rtc_time_set_and_round_properties.sv
`timescale 1ns/100ps
`default_nettype none
module rtc_time_set_and_round_properties
  import rtc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire mem_req_s req,
  input wire logic [15:0] rdata,
  input wire logic rvalid,
  input wire logic [15:0] minute_second_word,
  input wire logic [15:0] day_hour_word,
  input wire logic [15:0] year_month_word,
  input wire logic [15:0] weekday_value,
  input wire logic cmd_busy
);
  // ----------------------------------------------------------------
  // Shadow of the staged minute/second word
  // ----------------------------------------------------------------
  logic [15:0] stage_q;
  logic [15:0] stage_d;
  logic go;
  logic [7:0] sec;
  logic [7:0] min;
  logic wd_wr;
  logic [15:0] wdat;
  assign wd_wr = req.wr && req.idx == IDX_WEEKDAY;
  assign wdat = req.wdata;
  assign go = req.wr && req.idx == IDX_COMMAND && !cmd_busy;
  assign sec = minute_second_word[7:0];
  assign min = minute_second_word[15:8];
  always_comb begin
    stage_d = stage_q;
    if (req.wr && req.idx == IDX_MIN_SEC) begin
      stage_d = req.wdata;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage_q <= 16'h0000;
    end else begin
      stage_q <= stage_d;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_weekday_held;
    !$stable(weekday_value) |-> $past(wd_wr) || $past(wd_wr, 2);
  endproperty
  a_weekday_held: assert property (p_weekday_held) else $error("weekday changed without write");
  property p_bcd;
    sec[7:4] <= 4'h5 && sec[3:0] <= 4'h9 && min[7:4] <= 4'h5 && min[3:0] <= 4'h9;
  endproperty
  a_bcd: assert property (p_bcd) else $error("minute or second not BCD");
  property p_load;
    go && req.wdata[CMD_LOAD_BIT] |-> ##2 minute_second_word == $past(stage_q, 2);
  endproperty
  a_load: assert property (p_load) else $error("load did not apply staged time");
  property p_busy;
    go && (req.wdata[CMD_LOAD_BIT] || req.wdata[CMD_ROUND_BIT]) |-> ##[1:2] cmd_busy ##1 !cmd_busy;
  endproperty
  a_busy: assert property (p_busy) else $error("command not completed");
  property p_round_zero;
    go && req.wdata == 16'h0001 |-> ##[1:4] sec == 8'h00;
  endproperty
  a_round_zero: assert property (p_round_zero) else $error("round left seconds");
  property p_round_down;
    go && req.wdata == 16'h0001 && sec < ROUND_UP_FROM |-> ##2 minute_second_word == {$past(min, 2), 8'h00};
  endproperty
  a_round_down: assert property (p_round_down) else $error("round down wrong");
  property p_round_up;
    go && req.wdata == 16'h0001 && sec >= ROUND_UP_FROM && min[3:0] != 4'h9
      |-> ##2 minute_second_word == {8'($past(min, 2) + 8'h01), 8'h00};
  endproperty
  a_round_up: assert property (p_round_up) else $error("round up wrong");
  property p_tool;
    req.wr && req.tool && req.idx == IDX_MIN_SEC |-> ##2 minute_second_word == $past(wdat, 2);
  endproperty
  a_tool: assert property (p_tool) else $error("tool write not applied");
  property p_both;
    go && req.wdata == 16'h8001 |-> ##2 minute_second_word == $past(stage_q, 2);
  endproperty
  a_both: assert property (p_both) else $error("both bits did not load");
endmodule : rtc_time_set_and_round_properties
bind rtc_time_set_and_round rtc_time_set_and_round_properties chk_u (.clk(clk), .rst_b(rst_b), .req(req),
  .rdata(rdata), .rvalid(rvalid), .minute_second_word(minute_second_word), .day_hour_word(day_hour_word),
  .year_month_word(year_month_word), .weekday_value(weekday_value), .cmd_busy(cmd_busy));
`default_nettype wire

// ### bench/rtc_time_set_and_round_test.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin err_count++; $display("mismatch %s exp %h got %h", nm, exp, got); end end
module rtc_time_set_and_round_test
  import rtc_pkg::*;
;
  logic clk;
  logic rst_b;
  mem_req_s req;
  logic [15:0] rdata;
  logic rvalid;
  logic [15:0] ms_w;
  logic [15:0] dh_w;
  logic [15:0] ym_w;
  logic [15:0] wd_w;
  logic busy;
  int err_count;
  int checks;
  rtc_time_set_and_round dut_u (.clk(clk), .rst_b(rst_b), .req(req), .rdata(rdata), .rvalid(rvalid),
    .minute_second_word(ms_w), .day_hour_word(dh_w), .year_month_word(ym_w), .weekday_value(wd_w),
    .cmd_busy(busy));
  // ----------------------------------------------------------------
  // Port tasks
  // ----------------------------------------------------------------
  task automatic put(input logic [2:0] idx, input logic [15:0] data, input logic tool);
    req.wr = 1'b1;
    req.idx = idx;
    req.wdata = data;
    req.tool = tool;
    @(negedge clk);
    req = '0;
    @(negedge clk);
  endtask : put
  task automatic get(input logic [2:0] idx, output logic [15:0] data);
    int n;
    req.rd = 1'b1;
    req.idx = idx;
    @(negedge clk);
    req = '0;
    n = 0;
    while (rvalid !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    `CHK("rvalid", 1'b1, rvalid)
    data = rdata;
    @(negedge clk);
  endtask : get
  task automatic cmd(input logic [15:0] data);
    req.wr = 1'b1;
    req.idx = IDX_COMMAND;
    req.wdata = data;
    @(negedge clk);
    req = '0;
    `CHK("cmd_busy set", 1'b1, busy)
    @(negedge clk);
    `CHK("cmd_busy", 1'b0, busy)
    repeat (2) @(negedge clk);
  endtask : cmd
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic [15:0] d;
    `CHK("ms", 16'h0000, ms_w)
    `CHK("dh", 16'h0100, dh_w)
    `CHK("ym", 16'h0001, ym_w)
    get(3'h5, d);
    `CHK("unmapped", 16'h0000, d)
  endtask : t_reset
  task automatic t_load;
    logic [15:0] d;
    put(IDX_MIN_SEC, 16'h4715, 1'b0);
    put(IDX_DAY_HOUR, 16'h0512, 1'b0);
    put(IDX_YEAR_MONTH, 16'h2402, 1'b0);
    repeat (3) @(negedge clk);
    `CHK("ms staged only", 16'h0000, ms_w)
    cmd(16'h8000);
    `CHK("ms", 16'h4715, ms_w)
    `CHK("dh", 16'h0512, dh_w)
    `CHK("ym", 16'h2402, ym_w)
    get(IDX_COMMAND, d);
    `CHK("cmd", 16'h0000, d)
    get(IDX_MIN_SEC, d);
    `CHK("ms read", 16'h4715, d)
  endtask : t_load
  task automatic t_weekday;
    logic [15:0] d;
    put(IDX_WEEKDAY, 16'h0006, 1'b0);
    repeat (20) @(negedge clk);
    `CHK("weekday", 16'h0006, wd_w)
    get(IDX_WEEKDAY, d);
    `CHK("weekday read", 16'h0006, d)
  endtask : t_weekday
  task automatic t_round;
    logic [15:0] d;
    logic [15:0] tin[4] = '{16'h0529, 16'h0535, 16'h0500, 16'h5959};
    logic [15:0] tout[4] = '{16'h0500, 16'h0600, 16'h0500, 16'h0000};
    logic [15:0] tdh[4] = '{16'h0512, 16'h0512, 16'h0512, 16'h0513};
    for (int i = 0; i < 4; i++) begin
      put(IDX_MIN_SEC, tin[i], 1'b1);
      repeat (3) @(negedge clk);
      `CHK("tool ms", tin[i], ms_w)
      cmd(16'h0001);
      `CHK("round ms", tout[i], ms_w)
      `CHK("round dh", tdh[i], dh_w)
      get(IDX_COMMAND, d);
      `CHK("cmd", 16'h0000, d)
    end
  endtask : t_round
  task automatic t_both;
    logic [15:0] d;
    put(IDX_MIN_SEC, 16'h1045, 1'b0);
    cmd(16'h8001);
    `CHK("ms", 16'h1045, ms_w)
    get(IDX_COMMAND, d);
    `CHK("cmd", 16'h0000, d)
    `CHK("weekday", 16'h0006, wd_w)
  endtask : t_both
  task automatic t_carry;
    logic [15:0] d;
    logic [15:0] sdh[3] = '{16'h2823, 16'h2823, 16'h3123};
    logic [15:0] sym[3] = '{16'h2402, 16'h2302, 16'h9912};
    logic [15:0] sms[3] = '{16'h5945, 16'h5945, 16'h5930};
    logic [15:0] edh[3] = '{16'h2900, 16'h0100, 16'h0100};
    logic [15:0] eym[3] = '{16'h2402, 16'h2303, 16'h0001};
    for (int i = 0; i < 3; i++) begin
      put(IDX_DAY_HOUR, sdh[i], 1'b1);
      put(IDX_YEAR_MONTH, sym[i], 1'b1);
      put(IDX_MIN_SEC, sms[i], 1'b1);
      repeat (3) @(negedge clk);
      cmd(16'h0001);
      `CHK("carry ms", 16'h0000, ms_w)
      `CHK("carry dh", edh[i], dh_w)
      `CHK("carry ym", eym[i], ym_w)
    end
    // A command word with neither action bit is simply kept
    put(IDX_COMMAND, 16'h0010, 1'b0);
    get(IDX_COMMAND, d);
    `CHK("cmd kept", 16'h0010, d)
  endtask : t_carry
  task automatic close_out;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    req = '0;
    rst_b = 1'b0;
    err_count = 0;
    checks = 0;
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    t_reset();
    t_load();
    t_weekday();
    t_round();
    t_both();
    t_carry();
    close_out();
  end
  initial begin
    #20us;
    err_count++;
    close_out();
  end
endmodule : rtc_time_set_and_round_test
`default_nettype wire
